// *** core/deviation_defs.svh ***
// constants for the position deviation monitor
// included by bare name; definitions only
`ifndef DEVIATION_DEFS_SVH
`define DEVIATION_DEFS_SVH

`define DEV_POS_W 32
`define DEV_ERR_W 33
`define DEV_LIMIT_W 30
`define DEV_PCT_W 7
`define DEV_ADDR_W 4
`define DEV_DATA_W 32

// register offsets (byte addresses)
`define DEV_REG_ALARM_LIMIT 4'h0
`define DEV_REG_WARN_PCT 4'h4
`define DEV_REG_CONTROL 4'h8
`define DEV_REG_STATUS 4'hC

// control register bit positions
`define DEV_CTRL_POS_MODE 0
`define DEV_CTRL_ALARM_CLR 1

// reset values and legal ranges
`define DEV_LIMIT_RESET 30'h00500000
`define DEV_LIMIT_MIN 30'h00000001
`define DEV_LIMIT_MAX 30'h3FFFFFFF
`define DEV_PCT_RESET 7'h64
`define DEV_PCT_MIN 7'h0A
`define DEV_PCT_MAX 7'h64
`define DEV_PCT_DIV 7'h64

`endif

// *** core/deviation_pkg.sv ***
// types for the position deviation monitor
// needs deviation_defs.svh on the include path
`include "deviation_defs.svh"

package deviation_pkg;

  typedef logic signed [`DEV_ERR_W-1:0] err_t;
  typedef logic [`DEV_ERR_W-1:0] mag_t;
  typedef logic [`DEV_LIMIT_W-1:0] limit_t;
  typedef logic [`DEV_PCT_W-1:0] pct_t;

  typedef enum logic [1:0] {
    MON_IDLE = 2'b00,
    MON_WATCH = 2'b01,
    MON_TRIPPED = 2'b10
  } mon_state_t;

endpackage

// *** core/deviation_error_calc.sv ***
// position error and its magnitude, registered
// inputs are on clk_sys, no synchroniser needed
`timescale 1ns/100ps
`default_nettype none
`include "deviation_defs.svh"

module deviation_error_calc
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic sampleValid,
  input wire logic signed [`DEV_POS_W-1:0] commandPos,
  input wire logic signed [`DEV_POS_W-1:0] actualPos,
  output logic signed [`DEV_ERR_W-1:0] posError,
  output logic [`DEV_ERR_W-1:0] errMagnitude,
  output logic errValid
);

  typedef struct packed {
    deviation_pkg::err_t err;
    deviation_pkg::mag_t mag;
    logic valid;
  } calc_state_t;

  calc_state_t state_q;
  calc_state_t state_d;

  function automatic deviation_pkg::mag_t absVal(input deviation_pkg::err_t v);
    absVal = v[`DEV_ERR_W-1] ? deviation_pkg::mag_t'(-v) : deviation_pkg::mag_t'(v);
  endfunction

  // ----------------------------------------
  // error computation
  // ----------------------------------------
  always_comb
  begin
    deviation_pkg::err_t diff;
    diff = deviation_pkg::err_t'(commandPos) - deviation_pkg::err_t'(actualPos);
    state_d = state_q;
    state_d.valid = sampleValid;
    if (sampleValid)
    begin
      state_d.err = diff;
      state_d.mag = absVal(diff);
    end
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      state_q <= '0;
    else
      state_q <= state_d;
  end

  assign posError = state_q.err;
  assign errMagnitude = state_q.mag;
  assign errValid = state_q.valid;

  errorDiffCheck_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    sampleValid |=> posError == deviation_pkg::err_t'($past(commandPos)) - deviation_pkg::err_t'($past(actualPos)))
    else $error("position error is not command minus actual");

endmodule
`default_nettype wire

// *** core/deviation_threshold.sv ***
// warning threshold from limit and percentage
// limit and percentage come from registers on clk_sys
`timescale 1ns/100ps
`default_nettype none
`include "deviation_defs.svh"

module deviation_threshold
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [`DEV_LIMIT_W-1:0] alarmLimit,
  input wire logic [`DEV_PCT_W-1:0] warnPercent,
  output logic [`DEV_LIMIT_W-1:0] warnLimit
);

  typedef struct packed {
    deviation_pkg::limit_t warn;
  } thr_state_t;

  thr_state_t state_q;
  thr_state_t state_d;

  // ----------------------------------------
  // limit * percent / 100, one cycle
  // ----------------------------------------
  always_comb
  begin
    logic [`DEV_LIMIT_W+`DEV_PCT_W-1:0] prod;
    prod = {`DEV_PCT_W'h0, alarmLimit} * {`DEV_LIMIT_W'h0, warnPercent};
    state_d.warn = deviation_pkg::limit_t'(prod / `DEV_PCT_DIV);
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      state_q <= '0;
    else
      state_q <= state_d;
  end

  assign warnLimit = state_q.warn;

  warnNotAbove_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    ##1 warnLimit <= $past(alarmLimit))
    else $error("warning limit exceeds alarm limit");

endmodule
`default_nettype wire

// *** core/position_deviation_monitor.sv ***
// position deviation monitor: alarm, warning and motor stop
// register port on clk_sys; position samples from the loop on clk_sys
//
// Decided for this implementation: the strobed register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "deviation_defs.svh"

module position_deviation_monitor
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic sampleValid,
  input wire logic signed [`DEV_POS_W-1:0] commandPos,
  input wire logic signed [`DEV_POS_W-1:0] actualPos,
  input wire logic [`DEV_ADDR_W-1:0] regAddr,
  input wire logic [`DEV_DATA_W-1:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [`DEV_DATA_W-1:0] regRdata,
  output logic deviationOverflowAlarm,
  output logic deviationOverflowWarning,
  output logic motorStop
);

  typedef struct packed {
    deviation_pkg::limit_t limit;
    deviation_pkg::pct_t pct;
    logic posMode;
    logic alarm;
    logic warn;
    deviation_pkg::mon_state_t mon;
    logic [`DEV_DATA_W-1:0] rdata;
  } mon_reg_t;

  mon_reg_t state_q;
  mon_reg_t state_d;

  logic signed [`DEV_ERR_W-1:0] posError;
  logic [`DEV_ERR_W-1:0] errMagnitude;
  logic errValid;
  logic [`DEV_LIMIT_W-1:0] warnLimit;

  function automatic deviation_pkg::limit_t clampLimit(input logic [`DEV_DATA_W-1:0] v);
    if (v[`DEV_DATA_W-1:`DEV_LIMIT_W] != '0)
      clampLimit = `DEV_LIMIT_MAX;
    else if (v[`DEV_LIMIT_W-1:0] < `DEV_LIMIT_MIN)
      clampLimit = `DEV_LIMIT_MIN;
    else
      clampLimit = v[`DEV_LIMIT_W-1:0];
  endfunction

  function automatic deviation_pkg::pct_t clampPct(input logic [`DEV_DATA_W-1:0] v);
    if (v > {25'h0, `DEV_PCT_MAX})
      clampPct = `DEV_PCT_MAX;
    else if (v[`DEV_PCT_W-1:0] < `DEV_PCT_MIN)
      clampPct = `DEV_PCT_MIN;
    else
      clampPct = v[`DEV_PCT_W-1:0];
  endfunction

  function automatic logic exceeds(input deviation_pkg::mag_t m, input deviation_pkg::limit_t l);
    exceeds = m > {3'h0, l};
  endfunction

  // ----------------------------------------
  // submodules
  // ----------------------------------------
  deviation_error_calc u_calc
  (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .sampleValid(sampleValid),
    .commandPos(commandPos),
    .actualPos(actualPos),
    .posError(posError),
    .errMagnitude(errMagnitude),
    .errValid(errValid)
  );

  deviation_threshold u_thr
  (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .alarmLimit(state_q.limit),
    .warnPercent(state_q.pct),
    .warnLimit(warnLimit)
  );

  // ----------------------------------------
  // registers, comparisons, alarm state
  // ----------------------------------------
  always_comb
  begin
    logic overAlarm;
    logic overWarn;
    logic clearReq;
    overAlarm = exceeds(errMagnitude, state_q.limit);
    overWarn = exceeds(errMagnitude, warnLimit);
    clearReq = 1'b0;
    state_d = state_q;
    state_d.rdata = '0;
    if (regWrite)
    begin
      case (regAddr)
        `DEV_REG_ALARM_LIMIT: state_d.limit = clampLimit(regWdata);
        `DEV_REG_WARN_PCT: state_d.pct = clampPct(regWdata);
        `DEV_REG_CONTROL:
        begin
          state_d.posMode = regWdata[`DEV_CTRL_POS_MODE];
          clearReq = regWdata[`DEV_CTRL_ALARM_CLR];
        end
        default: state_d.pct = state_q.pct;
      endcase
    end
    if (regRead)
    begin
      case (regAddr)
        `DEV_REG_ALARM_LIMIT: state_d.rdata = {2'h0, state_q.limit};
        `DEV_REG_WARN_PCT: state_d.rdata = {25'h0, state_q.pct};
        `DEV_REG_CONTROL: state_d.rdata = {31'h0, state_q.posMode};
        `DEV_REG_STATUS: state_d.rdata = {28'h0, state_q.mon, state_q.warn, state_q.alarm};
        default: state_d.rdata = '0;
      endcase
    end
    case (state_q.mon)
      deviation_pkg::MON_IDLE:
      begin
        state_d.warn = 1'b0;
        if (state_q.posMode)
          state_d.mon = deviation_pkg::MON_WATCH;
      end
      deviation_pkg::MON_WATCH:
      begin
        if (!state_q.posMode)
        begin
          state_d.mon = deviation_pkg::MON_IDLE;
          state_d.warn = 1'b0;
        end
        else if (errValid)
        begin
          state_d.warn = overWarn;
          if (overAlarm)
          begin
            state_d.alarm = 1'b1;
            state_d.mon = deviation_pkg::MON_TRIPPED;
          end
        end
      end
      deviation_pkg::MON_TRIPPED:
      begin
        if (state_q.posMode && errValid)
          state_d.warn = overWarn;
        else if (!state_q.posMode)
          state_d.warn = 1'b0;
        // a fresh overflow in the clear cycle keeps the alarm
        if (clearReq && !(state_q.posMode && errValid && overAlarm))
        begin
          state_d.alarm = 1'b0;
          state_d.mon = deviation_pkg::MON_IDLE;
        end
      end
      default: state_d.mon = deviation_pkg::MON_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q <= '0;
      state_q.limit <= `DEV_LIMIT_RESET;
      state_q.pct <= `DEV_PCT_RESET;
    end
    else
      state_q <= state_d;
  end

  assign regRdata = state_q.rdata;
  assign deviationOverflowAlarm = state_q.alarm;
  assign deviationOverflowWarning = state_q.warn;
  assign motorStop = state_q.alarm;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  alarmOnExcess_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (state_q.mon == deviation_pkg::MON_WATCH && state_q.posMode && errValid
      && errMagnitude > {3'h0, state_q.limit}) |=> deviationOverflowAlarm)
    else $error("alarm missed on excess error");

  stopWithAlarm_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    $rose(deviationOverflowAlarm) |-> motorStop ##1 motorStop)
    else $error("motor not stopped on alarm");

  modeGate_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (!state_q.posMode && !deviationOverflowAlarm) |=> !$rose(deviationOverflowAlarm))
    else $error("alarm raised outside position mode");

  limitRange_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (regWrite && regAddr == `DEV_REG_ALARM_LIMIT) |=>
      state_q.limit >= `DEV_LIMIT_MIN && state_q.limit == clampLimit($past(regWdata)))
    else $error("alarm limit write not applied");

  pctRange_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    ##1 (state_q.pct >= `DEV_PCT_MIN && state_q.pct <= `DEV_PCT_MAX))
    else $error("warning percent out of range");

  alarmLatched_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (deviationOverflowAlarm && !(regWrite && regAddr == `DEV_REG_CONTROL
      && regWdata[`DEV_CTRL_ALARM_CLR])) |=> deviationOverflowAlarm)
    else $error("alarm dropped without clear");

  warnLive_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (state_q.mon == deviation_pkg::MON_WATCH && state_q.posMode && errValid)
      |=> deviationOverflowWarning == ($past(errMagnitude) > {3'h0, $past(warnLimit)}))
    else $error("warning does not follow comparison");

  readLatency_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (regRead && regAddr == `DEV_REG_ALARM_LIMIT && !regWrite) |=> regRdata == {2'h0, $past(state_q.limit)})
    else $error("limit readback wrong");

  pctReadback_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (regRead && regAddr == `DEV_REG_WARN_PCT && !regWrite) |=> regRdata == {25'h0, $past(state_q.pct)})
    else $error("percent readback wrong");

  statusRead_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (regRead && regAddr == `DEV_REG_STATUS) |=>
      regRdata == {28'h0, $past(state_q.mon), $past(deviationOverflowWarning), $past(deviationOverflowAlarm)})
    else $error("status readback wrong");

  pctWrite_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (regWrite && regAddr == `DEV_REG_WARN_PCT) |=> state_q.pct == clampPct($past(regWdata)))
    else $error("warning percent write not applied");

  limitKept_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    !(regWrite && regAddr == `DEV_REG_ALARM_LIMIT) |=> $stable(state_q.limit))
    else $error("alarm limit changed without write");

  pctKept_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    !(regWrite && regAddr == `DEV_REG_WARN_PCT) |=> $stable(state_q.pct))
    else $error("warning percent changed without write");

  // ----------------------------------------
  // alarm state and mode checks
  // ----------------------------------------
  noFalseAlarm_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    $rose(deviationOverflowAlarm) |->
      ($past(state_q.posMode) && $past(errValid) && $past(errMagnitude) > {3'h0, $past(state_q.limit)}))
    else $error("alarm raised without excess error");

  warnOffMode_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    !state_q.posMode |=> !deviationOverflowWarning)
    else $error("warning raised outside position mode");

  warnIdle_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (state_q.mon == deviation_pkg::MON_IDLE)
      |=> !deviationOverflowWarning)
    else $error("warning raised while idle");

  idleStep_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (state_q.mon == deviation_pkg::MON_IDLE && state_q.posMode)
      |=> state_q.mon == deviation_pkg::MON_WATCH)
    else $error("monitor did not start watching");

  leaveWatch_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (state_q.mon == deviation_pkg::MON_WATCH && !state_q.posMode)
      |=> (state_q.mon == deviation_pkg::MON_IDLE && !deviationOverflowWarning))
    else $error("monitor kept watching outside position mode");

  clearDrops_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (deviationOverflowAlarm && regWrite && regAddr == `DEV_REG_CONTROL && regWdata[`DEV_CTRL_ALARM_CLR]
      && !(state_q.posMode && errValid && errMagnitude > {3'h0, state_q.limit}))
      |=> !deviationOverflowAlarm)
    else $error("alarm clear not applied");

  setWins_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (deviationOverflowAlarm && state_q.posMode && errValid && errMagnitude > {3'h0, state_q.limit})
      |=> deviationOverflowAlarm)
    else $error("clear beat a fresh overflow");

  trippedAlarm_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    deviationOverflowAlarm == (state_q.mon == deviation_pkg::MON_TRIPPED))
    else $error("alarm and tripped state disagree");

  stopEqual_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    motorStop == deviationOverflowAlarm)
    else $error("motor stop differs from alarm");

  warnTripped_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (state_q.mon == deviation_pkg::MON_TRIPPED && state_q.posMode && errValid)
      |=> deviationOverflowWarning == ($past(errMagnitude) > {3'h0, $past(warnLimit)}))
    else $error("warning frozen while tripped");

endmodule
`default_nettype wire

// *** bench/position_loop_model.sv ***
// position loop stand-in: a moving axis with a set following error
// assumes the clk_sys and resetn of the monitor
`timescale 1ns/100ps
`default_nettype none

module position_loop_model
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic signed [31:0] errSet,
  output logic sampleValid,
  output logic signed [31:0] commandPos,
  output logic signed [31:0] actualPos
);
  logic signed [31:0] axisPos_q;

  // axis creeps so both positions change every sample
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      axisPos_q <= 32'sh00001000;
    else
      axisPos_q <= axisPos_q + 32'sh00000003;
  end

  assign sampleValid = resetn;
  assign commandPos = axisPos_q + errSet;
  assign actualPos = axisPos_q;
endmodule
`default_nettype wire

// *** bench/position_deviation_monitor_tb.sv ***
// bench for the position deviation monitor
// assumes core files compiled first; clk_sys at 50 MHz
`timescale 1ns/100ps
`default_nettype none
`include "deviation_defs.svh"

module position_deviation_monitor_tb;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [31:0] regWdata = 32'h0;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic signed [31:0] errSet = 32'sh0;
  wire logic sampleValid;
  wire logic signed [31:0] commandPos;
  wire logic signed [31:0] actualPos;
  wire logic [31:0] regRdata;
  wire logic alarm;
  wire logic warning;
  wire logic motorStop;
  int errors = 0;
  int checks_done = 0;

  always #10 clk_sys = ~clk_sys;

  position_loop_model loop (.clk_sys(clk_sys), .resetn(resetn), .errSet(errSet),
    .sampleValid(sampleValid), .commandPos(commandPos), .actualPos(actualPos));

  position_deviation_monitor dut (.clk_sys(clk_sys), .resetn(resetn),
    .sampleValid(sampleValid), .commandPos(commandPos), .actualPos(actualPos),
    .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
    .regRdata(regRdata), .deviationOverflowAlarm(alarm),
    .deviationOverflowWarning(warning), .motorStop(motorStop));

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk_sys);
    regWrite <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk_sys);
    regRead <= 1'b0;
    #1;
    chk(regRdata, exp);
  endtask

  // new error, then let sample, error and flag stages land
  task automatic err(input logic signed [31:0] e);
    @(posedge clk_sys);
    errSet <= e;
    repeat (5) @(posedge clk_sys);
    #1;
  endtask

  // expected alarm, warning, stop
  task automatic flags(input logic [2:0] e);
    chk({29'h0, alarm, warning, motorStop}, {29'h0, e});
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial
  begin
    repeat (8) @(posedge clk_sys);
    resetn <= 1'b1;
    rd(`DEV_REG_ALARM_LIMIT, 32'h00500000);
    rd(`DEV_REG_WARN_PCT, 32'h00000064);
    rd(`DEV_REG_CONTROL, 32'h0);
    rd(4'h2, 32'h0);
    $display("test reset values done");
    wr(`DEV_REG_ALARM_LIMIT, 32'h0);
    rd(`DEV_REG_ALARM_LIMIT, 32'h1);
    wr(`DEV_REG_ALARM_LIMIT, 32'hFFFFFFFF);
    rd(`DEV_REG_ALARM_LIMIT, 32'h3FFFFFFF);
    wr(`DEV_REG_WARN_PCT, 32'h9);
    rd(`DEV_REG_WARN_PCT, 32'hA);
    wr(`DEV_REG_WARN_PCT, 32'h65);
    rd(`DEV_REG_WARN_PCT, 32'h64);
    $display("test range ends done");
    wr(`DEV_REG_ALARM_LIMIT, 32'h3E8);
    wr(`DEV_REG_WARN_PCT, 32'h32);
    err(32'sd5000);
    flags(3'b000);
    err(32'sd0);
    wr(`DEV_REG_CONTROL, 32'h1);
    err(32'sd500);
    flags(3'b000);
    err(32'sd501);
    flags(3'b010);
    err(32'sd1000);
    flags(3'b010);
    err(32'sd1001);
    flags(3'b111);
    err(32'sd0);
    flags(3'b101);
    rd(`DEV_REG_STATUS, 32'h9);
    wr(`DEV_REG_CONTROL, 32'h3);
    err(32'sd0);
    flags(3'b000);
    rd(`DEV_REG_CONTROL, 32'h1);
    err(-32'sd1001);
    flags(3'b111);
    err(32'sd0);
    wr(`DEV_REG_CONTROL, 32'h3);
    err(32'sd600);
    flags(3'b010);
    rd(`DEV_REG_STATUS, 32'h6);
    wr(`DEV_REG_CONTROL, 32'h0);
    err(32'sd600);
    flags(3'b000);
    $display("test thresholds done");
    wr(`DEV_REG_CONTROL, 32'h1);
    wr(`DEV_REG_WARN_PCT, 32'h64);
    err(32'sd800);
    flags(3'b000);
    wr(`DEV_REG_WARN_PCT, 32'h4F);
    err(32'sd800);
    flags(3'b010);
    wr(`DEV_REG_ALARM_LIMIT, 32'h31F);
    err(32'sd800);
    flags(3'b111);
    wr(`DEV_REG_CONTROL, 32'h3);
    err(32'sd800);
    flags(3'b111);
    wr(`DEV_REG_ALARM_LIMIT, 32'h3E8);
    wr(`DEV_REG_CONTROL, 32'h3);
    err(32'sd800);
    flags(3'b010);
    $display("test live settings done");
    results();
  end

  initial
  begin
    #400000;
    errors++;
    results();
  end
endmodule
`default_nettype wire
